//--- mcsel_pkg.sv
// Shared constants for the multichannel select register bank
package mcsel_pkg;
  localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
  localparam logic [3:0]  RX_ENABLE_OFFSET = 4'h4;
  localparam logic [3:0]  TX_ENABLE_OFFSET = 4'h8;
  localparam int          RX_SELECT_BIT    = 0;
  localparam int          RESERVED_BIT     = 1;
  localparam int          RX_CUR_LSB       = 2;
  localparam int          RX_EVEN_LSB      = 5;
  localparam int          RX_ODD_LSB       = 7;
  localparam int          TX_EVEN_LSB      = 21;
  localparam int          TX_ODD_LSB       = 23;
  localparam logic [31:0] MASK_RESET       = 32'h0;
  localparam logic [1:0]  SELECT_RESET     = 2'h0;
  localparam int          CHANNELS         = 128;
  localparam int          SUBFRAME_SIZE    = 16;
endpackage

//--- mcsel_if.sv
// Channel query carrier between top and channel decoders
`timescale 1ns/1ps
interface mcsel_if;
  logic [6:0]  channel;
  logic [1:0]  evenSelect;
  logic [1:0]  oddSelect;
  logic [31:0] mask;
  logic        selectOn;
  logic        enabled;
  modport owner   (output channel, evenSelect, oddSelect, mask, selectOn, input enabled);
  modport decoder (input channel, evenSelect, oddSelect, mask, selectOn, output enabled);
endinterface

//--- channel_enable_decode.sv
// Maps a channel number onto the even/odd mask halves
`timescale 1ns/1ps
module channel_enable_decode
  import mcsel_pkg::*;
(
  mcsel_if.decoder q
);
  logic [2:0] subframe;
  logic [3:0] slot;
  always_comb
  begin
    subframe  = q.channel[6:4];
    slot      = q.channel[3:0];
    q.enabled = 1'b0;
    if (!q.selectOn)
      q.enabled = 1'b1;
    else if (subframe == {q.evenSelect, 1'b0})
      q.enabled = q.mask[{1'b0, slot}];
    else if (subframe == {q.oddSelect, 1'b1})
      q.enabled = q.mask[{1'b1, slot}];
  end
endmodule

//--- multichannel_select_regs.sv
// Multichannel select control and channel enable registers
// Notes on behaviour
// - Bits 6-5 pick rx even subframe: 0,2,4,6.
// - Bits 8-7 pick rx odd subframe: 1,3,5,7.
// - Bits 4-2 report current rx subframe, read only.
// - Control bit 1 reads zero, writes ignored.
// - Select bit clear: all 128 rx channels enabled.
// - Select bit set: rx channels off unless mask enables them.
// - Rx mask holds 32 elements, 16 even and 16 odd.
// - Rx mask low half enables channels of even subframe.
// - Rx mask high half enables channels of odd subframe.
// - Tx mask holds 32 elements split by tx selects.
// - Tx mask low half enables channels of even subframe.
// - Tx mask high half enables channels of odd subframe.
// - Bits 22-21 pick tx even subframe, same mapping.
`timescale 1ns/1ps
module multichannel_select_regs
  import mcsel_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic [6:0]  rxChannel,
  output logic             rxChannelEnabled,
  input  wire logic [6:0]  txChannel,
  output logic             txChannelEnabled
);
  logic        rxSelectOn_r, rxSelectOn_nxt;
  logic [1:0]  rxEven_r, rxEven_nxt;
  logic [1:0]  rxOdd_r, rxOdd_nxt;
  logic [1:0]  txEven_r, txEven_nxt;
  logic [1:0]  txOdd_r, txOdd_nxt;
  logic [31:0] rxMask_r, rxMask_nxt;
  logic [31:0] txMask_r, txMask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ctrlView;

  mcsel_if rxQ ();
  mcsel_if txQ ();

  // Current subframe follows the channel slot under evaluation
  always_comb
  begin
    ctrlView = 32'h0;
    ctrlView[RX_SELECT_BIT] = rxSelectOn_r;
    ctrlView[RESERVED_BIT] = 1'b0;
    ctrlView[RX_CUR_LSB +: 3] = rxChannel[6:4];
    ctrlView[RX_EVEN_LSB +: 2] = rxEven_r;
    ctrlView[RX_ODD_LSB +: 2] = rxOdd_r;
    ctrlView[TX_EVEN_LSB +: 2] = txEven_r;
    ctrlView[TX_ODD_LSB +: 2] = txOdd_r;
  end

  always_comb
  begin
    rxSelectOn_nxt = rxSelectOn_r;
    rxEven_nxt     = rxEven_r;
    rxOdd_nxt      = rxOdd_r;
    txEven_nxt     = txEven_r;
    txOdd_nxt      = txOdd_r;
    rxMask_nxt     = rxMask_r;
    txMask_nxt     = txMask_r;
    rdata_nxt      = 32'h0;
    if (regWrite)
    begin
      unique case (regAddr)
        CTRL_OFFSET:
        begin
          rxSelectOn_nxt = regWdata[RX_SELECT_BIT];
          rxEven_nxt     = regWdata[RX_EVEN_LSB +: 2];
          rxOdd_nxt      = regWdata[RX_ODD_LSB +: 2];
          txEven_nxt     = regWdata[TX_EVEN_LSB +: 2];
          txOdd_nxt      = regWdata[TX_ODD_LSB +: 2];
        end
        RX_ENABLE_OFFSET: rxMask_nxt = regWdata;
        TX_ENABLE_OFFSET: txMask_nxt = regWdata;
        default: ;
      endcase
    end
    if (regRead)
    begin
      unique case (regAddr)
        CTRL_OFFSET:      rdata_nxt = ctrlView;
        RX_ENABLE_OFFSET: rdata_nxt = rxMask_r;
        TX_ENABLE_OFFSET: rdata_nxt = txMask_r;
        default:          rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxSelectOn_r <= 1'b0;
      rxEven_r     <= SELECT_RESET;
      rxOdd_r      <= SELECT_RESET;
      txEven_r     <= SELECT_RESET;
      txOdd_r      <= SELECT_RESET;
      rxMask_r     <= MASK_RESET;
      txMask_r     <= MASK_RESET;
      rdata_r      <= 32'h0;
    end
    else
    begin
      rxSelectOn_r <= rxSelectOn_nxt;
      rxEven_r     <= rxEven_nxt;
      rxOdd_r      <= rxOdd_nxt;
      txEven_r     <= txEven_nxt;
      txOdd_r      <= txOdd_nxt;
      rxMask_r     <= rxMask_nxt;
      txMask_r     <= txMask_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

  assign rxQ.channel    = rxChannel;
  assign rxQ.evenSelect = rxEven_r;
  assign rxQ.oddSelect  = rxOdd_r;
  assign rxQ.mask       = rxMask_r;
  assign rxQ.selectOn   = rxSelectOn_r;
  // Transmit side has no mode field here, so masks always apply
  assign txQ.channel    = txChannel;
  assign txQ.evenSelect = txEven_r;
  assign txQ.oddSelect  = txOdd_r;
  assign txQ.mask       = txMask_r;
  assign txQ.selectOn   = 1'b1;

  channel_enable_decode rxDecode (.q(rxQ));
  channel_enable_decode txDecode (.q(txQ));

  // Lookup is combinational so a new mask acts on the next slot
  assign rxChannelEnabled = rxQ.enabled;
  assign txChannelEnabled = txQ.enabled;

  a_rx_all_open: assert property (@(posedge core_clk) disable iff (!rstn)
    !rxSelectOn_r |-> rxChannelEnabled)
    else $error("rx channel blocked while select off");
  a_rx_even_map: assert property (@(posedge core_clk) disable iff (!rstn)
    (rxSelectOn_r && rxChannel[6:4] == {rxEven_r, 1'b0})
      |-> rxChannelEnabled == rxMask_r[rxChannel[3:0]])
    else $error("rx even mapping wrong");
  a_rx_odd_map: assert property (@(posedge core_clk) disable iff (!rstn)
    (rxSelectOn_r && rxChannel[6:4] == {rxOdd_r, 1'b1})
      |-> rxChannelEnabled == rxMask_r[16 + rxChannel[3:0]])
    else $error("rx odd mapping wrong");
  a_rx_unselected_off: assert property (@(posedge core_clk) disable iff (!rstn)
    (rxSelectOn_r && rxChannel[6:4] != {rxEven_r, 1'b0}
      && rxChannel[6:4] != {rxOdd_r, 1'b1}) |-> !rxChannelEnabled)
    else $error("rx unselected channel enabled");
  a_tx_even_map: assert property (@(posedge core_clk) disable iff (!rstn)
    (txChannel[6:4] == {txEven_r, 1'b0})
      |-> txChannelEnabled == txMask_r[txChannel[3:0]])
    else $error("tx even mapping wrong");
  a_tx_odd_map: assert property (@(posedge core_clk) disable iff (!rstn)
    (txChannel[6:4] == {txOdd_r, 1'b1})
      |-> txChannelEnabled == txMask_r[16 + txChannel[3:0]])
    else $error("tx odd mapping wrong");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRead && regAddr == CTRL_OFFSET) |=> !regRdata[RESERVED_BIT])
    else $error("reserved bit read as one");
  a_mask_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrite && regAddr == RX_ENABLE_OFFSET) |=> rxMask_r == $past(regWdata))
    else $error("rx mask not written");
  a_tx_sel_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrite && regAddr == CTRL_OFFSET)
      |=> txEven_r == $past(regWdata[TX_EVEN_LSB +: 2]))
    else $error("tx even select not written");
  a_rx_sel_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (regWrite && regAddr == CTRL_OFFSET)
      |=> rxEven_r == $past(regWdata[RX_EVEN_LSB +: 2])
        && rxOdd_r == $past(regWdata[RX_ODD_LSB +: 2]))
    else $error("rx selects not written");

  // Register strobes, used as first steps of multi-cycle checks
  sequence s_rx_mask_wr;
    regWrite && regAddr == RX_ENABLE_OFFSET;
  endsequence

  sequence s_tx_mask_wr;
    regWrite && regAddr == TX_ENABLE_OFFSET;
  endsequence

  sequence s_ctrl_wr;
    regWrite && regAddr == CTRL_OFFSET;
  endsequence

  sequence s_ctrl_rd;
    regRead && regAddr == CTRL_OFFSET;
  endsequence

  sequence s_rx_mask_rd;
    regRead && regAddr == RX_ENABLE_OFFSET;
  endsequence

  sequence s_tx_mask_rd;
    regRead && regAddr == TX_ENABLE_OFFSET;
  endsequence

  a_tx_mask_write: assert property (@(posedge core_clk) disable iff (!rstn)
    s_tx_mask_wr |=> txMask_r == $past(regWdata))
    else $error("tx mask not written");

  a_tx_odd_write: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ctrl_wr |=> txOdd_r == $past(regWdata[TX_ODD_LSB +: 2]))
    else $error("tx odd select not written");

  a_sel_on_write: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ctrl_wr |=> rxSelectOn_r == $past(regWdata[RX_SELECT_BIT]))
    else $error("rx select enable not written");

  // Tx has no all-open mode, so channels outside both subframes stay off
  a_tx_unselected_off: assert property (@(posedge core_clk) disable iff (!rstn)
    (txChannel[6:4] != {txEven_r, 1'b0}
      && txChannel[6:4] != {txOdd_r, 1'b1}) |-> !txChannelEnabled)
    else $error("tx unselected channel enabled");

  a_cur_sub_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ctrl_rd |=> regRdata[RX_CUR_LSB +: 3] == $past(rxChannel[6:4]))
    else $error("current subframe read wrong");

  a_ctrl_sel_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ctrl_rd |=> regRdata[RX_EVEN_LSB +: 2] == $past(rxEven_r)
      && regRdata[RX_ODD_LSB +: 2] == $past(rxOdd_r))
    else $error("rx selects read wrong");

  a_ctrl_tx_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ctrl_rd |=> regRdata[TX_EVEN_LSB +: 2] == $past(txEven_r))
    else $error("tx even select read wrong");

  a_ctrl_high_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ctrl_rd |=> regRdata[31:25] == 7'h0 && regRdata[20:9] == 12'h0)
    else $error("unused control bits read as one");

  a_rx_mask_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s_rx_mask_rd |=> regRdata == $past(rxMask_r))
    else $error("rx mask read wrong");

  a_tx_mask_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s_tx_mask_rd |=> regRdata == $past(txMask_r))
    else $error("tx mask read wrong");

  a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rstn)
    (regRead && regAddr != CTRL_OFFSET && regAddr != RX_ENABLE_OFFSET
      && regAddr != TX_ENABLE_OFFSET) |=> regRdata == 32'h0)
    else $error("unmapped read not zero");

  // Read data must not linger, or software could see a stale word
  a_idle_read_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    !regRead |=> regRdata == 32'h0)
    else $error("read data stands too long");

  a_rx_mask_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == RX_ENABLE_OFFSET) |=> $stable(rxMask_r))
    else $error("rx mask changed without write");

  a_tx_mask_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == TX_ENABLE_OFFSET) |=> $stable(txMask_r))
    else $error("tx mask changed without write");

  a_ctrl_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == CTRL_OFFSET)
      |=> $stable(rxSelectOn_r) && $stable(rxEven_r) && $stable(rxOdd_r)
        && $stable(txEven_r) && $stable(txOdd_r))
    else $error("control changed without write");

  a_rx_next_slot: assert property (@(posedge core_clk) disable iff (!rstn)
    s_rx_mask_wr ##1 (rxSelectOn_r && rxChannel[6:4] == {rxEven_r, 1'b0})
      |-> rxMask_r == $past(regWdata)
        && rxChannelEnabled == rxMask_r[rxChannel[3:0]])
    else $error("rx mask write late");

  a_tx_next_slot: assert property (@(posedge core_clk) disable iff (!rstn)
    s_tx_mask_wr ##1 (txChannel[6:4] == {txOdd_r, 1'b1})
      |-> txMask_r == $past(regWdata)
        && txChannelEnabled == txMask_r[16 + txChannel[3:0]])
    else $error("tx mask write late");

  a_rx_wr_rd: assert property (@(posedge core_clk) disable iff (!rstn)
    s_rx_mask_wr ##1 s_rx_mask_rd |=> regRdata == $past(regWdata, 2))
    else $error("rx mask read after write wrong");

  a_tx_wr_rd: assert property (@(posedge core_clk) disable iff (!rstn)
    s_tx_mask_wr ##1 s_tx_mask_rd |=> regRdata == $past(regWdata, 2))
    else $error("tx mask read after write wrong");

  // Sampled with no disable so the reset state itself is watched
  a_reset_masks: assert property (@(posedge core_clk)
    !rstn |-> rxMask_r == MASK_RESET && txMask_r == MASK_RESET)
    else $error("masks not cleared in reset");

  a_reset_rdata: assert property (@(posedge core_clk)
    !rstn |-> regRdata == 32'h0)
    else $error("read data not cleared in reset");

  a_reset_rx_open: assert property (@(posedge core_clk)
    !rstn |-> rxChannelEnabled)
    else $error("rx channels closed in reset");

  a_reset_tx_closed: assert property (@(posedge core_clk)
    !rstn |-> !txChannelEnabled)
    else $error("tx channel open in reset");
endmodule

//--- tb_top.sv
// Self-checking bench for the multichannel select register bank
`timescale 1ns/1ps
module tb_top;
  import mcsel_pkg::*;
  logic        core_clk;
  logic        rstn;
  logic        regWrite;
  logic        regRead;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic [6:0]  rxChannel;
  logic [6:0]  txChannel;
  logic        rxChannelEnabled;
  logic        txChannelEnabled;
  logic        rdSeen = 1'b0;
  logic [31:0] lfsr;
  logic [31:0] rxM;
  logic [31:0] txM;
  logic [31:0] expQ[$];
  int          fails;
  int          checksDone;

  multichannel_select_regs multichannel_select_regs_i (.core_clk(core_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .rxChannel(rxChannel), .rxChannelEnabled(rxChannelEnabled),
    .txChannel(txChannel), .txChannelEnabled(txChannelEnabled));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want)
    begin
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      fails++;
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && checksDone > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] nextRand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic chEn(input logic [6:0] ch, input logic [1:0] ev,
                                input logic [1:0] od, input logic [31:0] m);
    if (ch[6:4] == {ev, 1'b0})
      return m[ch[3:0]];
    if (ch[6:4] == {od, 1'b1})
      return m[{1'b1, ch[3:0]}];
    return 1'b0;
  endfunction

  // Strobes stay up until the next call, so calls chain back to back
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge core_clk);
    regWrite <= w;
    regRead  <= r;
    regAddr  <= a;
    regWdata <= d;
    if (r)
      expQ.push_back(e);
  endtask

  // Ones written to reserved and read-only bits must not stick
  task automatic sweep(input logic on, input logic [1:0] ev, input logic [1:0] od);
    bus(1, 0, CTRL_OFFSET, {7'h0, od, ev, 12'h0, od, ev, 3'h7, 1'b1, on}, 0);
    bus(0, 0, 4'h0, 0, 0);
    for (int c = 0; c < CHANNELS; c++)
    begin
      @(posedge core_clk);
      rxChannel <= 7'(c);
      txChannel <= 7'(c) ^ 7'h55;
      @(negedge core_clk);
      chk({31'h0, rxChannelEnabled}, on ? {31'h0, chEn(7'(c), ev, od, rxM)} : 1);
      chk({31'h0, txChannelEnabled}, {31'h0, chEn(7'(c) ^ 7'h55, ev, od, txM)});
    end
    @(posedge core_clk);
    rxChannel <= {od[0], ev, 4'h9};
    bus(0, 1, CTRL_OFFSET, 0, {7'h0, od, ev, 12'h0, od, ev, od[0], ev, 1'b0, on});
  endtask

  always @(posedge core_clk)
    rdSeen <= regRead;

  // Read data stands only in the cycle after the strobe
  always @(negedge core_clk)
    if (rstn)
    begin
      if (rdSeen)
        chk(regRdata, expQ.pop_front());
      else
        chk(regRdata, 32'h0);
    end

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (100000) @(posedge core_clk);
    fails++;
    print_verdict();
  end

  initial
  begin
    {rstn, regWrite, regRead, regAddr, regWdata, rxChannel, txChannel} = '0;
    lfsr = 32'h4d37;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({31'h0, rxChannelEnabled}, 1);
    bus(0, 1, CTRL_OFFSET, 0, 0);
    bus(0, 1, RX_ENABLE_OFFSET, 0, MASK_RESET);
    bus(0, 1, TX_ENABLE_OFFSET, 0, MASK_RESET);
    for (int k = 0; k < 5; k++)
    begin
      rxM = nextRand();
      txM = nextRand();
      bus(1, 0, RX_ENABLE_OFFSET, rxM, 0);
      bus(1, 0, TX_ENABLE_OFFSET, txM, 0);
      bus(0, 1, RX_ENABLE_OFFSET, 0, rxM);
      bus(0, 1, TX_ENABLE_OFFSET, 0, txM);
      bus(1, 0, 4'hc, nextRand(), 0);
      bus(0, 1, 4'hc, 0, 0);
      sweep(k != 4, 2'(k), ~2'(k));
    end
    bus(0, 0, 4'h0, 0, 0);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule
